// *** verilog/cbs_consts.svh ***
// Offsets, fields, reset values and counts of the bus control block.
// Assumes one AHB-Lite slave with 32-bit data and word registers.
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

// Register byte offsets.
`define CBS_OFF_CTRL      8'h00
`define CBS_OFF_ADDR      8'h04
`define CBS_OFF_WDATA     8'h08
`define CBS_OFF_CMD       8'h0C
`define CBS_OFF_STATUS    8'h10
`define CBS_OFF_RDATA     8'h14

// Control fields and reset value.
`define CBS_CTRL_IFF      0
`define CBS_CTRL_MODE_LO  1
`define CBS_CTRL_MODE_HI  2
`define CBS_CTRL_RESET    32'h0000_0000

// Status fields.
`define CBS_ST_BUSY       0
`define CBS_ST_HALTED     1
`define CBS_ST_GRANTED    2
`define CBS_ST_NMI        3
`define CBS_ST_CLKHELD    4
`define CBS_ST_MODE_LO    5
`define CBS_ST_ACK_LO     8
`define CBS_ST_REFR_LO    16

// Cycle kinds; the command register takes all but the acknowledge.
`define CBS_KIND_FETCH    3'h0
`define CBS_KIND_MEMRD    3'h1
`define CBS_KIND_MEMWR    3'h2
`define CBS_KIND_IORD     3'h3
`define CBS_KIND_IOWR     3'h4
`define CBS_KIND_HALT     3'h5
`define CBS_KIND_INTA     3'h6

// Mode select pin codes, first pin in the upper bit.
`define CBS_MODE_RUN      2'h3
`define CBS_MODE_OSC_ONLY_STANDBY    2'h0
`define CBS_MODE_CLOCK_OUT_STANDBY    2'h1
`define CBS_MODE_STOP     2'h2

// Acknowledge codes.
`define CBS_ACK_NMI       2'h1
`define CBS_ACK_INT       2'h2

// Automatic wait states per cycle kind, and the extra T2 dwell for pin latency.
`define CBS_AUTO_WAIT_IO   3'h1
`define CBS_AUTO_WAIT_INTA 3'h2
`define CBS_SYNC_WAIT      3'h2

// Warm-up in half periods, and in whole cycles rounded up.
`define CBS_WARM_HALF_PERIODS 32773
`define CBS_WARM_CYCLES       ((`CBS_WARM_HALF_PERIODS + 1) / 2)

`endif

// *** verilog/cbs_pkg.sv ***
// Types shared by the bus control block: machine cycle states and the bus pin bundle.
// Assumes the constants header supplies every number.
`default_nettype none
package cbs_pkg;

  // Machine cycle sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_HALT, ST_WARM, ST_ACK, ST_HOLD
  } cbs_state_e;

  // Driven bus pins, all strobes active low.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        memReqN;
    logic        portReqN;
    logic        readN;
    logic        writeN;
    logic        firstN;
  } cbs_pins_s;

endpackage : cbs_pkg
`default_nettype wire

// *** verilog/cbs_bus_control.sv ***
// Bus cycle, bus hold and halt standby sequencer,
// driven by software over AHB-Lite.
// Assumes one 50 MHz clock and a synchronous reset.
// Pin inputs come from outside this clock domain.
//
// Operation
// - mode pins pick one of four halt modes
// - maskable request needs enable set
// - non-maskable first, ignores enable
// - halt output low once halted
// - memory strobe only with valid address
// - port strobe with port address
// - acknowledge: port strobe with marker
// - read strobe low while data taken
// - write strobe while write data valid
// - grant once bus and strobes float
// - wait while wait input low
// - marker with memory strobe each fetch
// - marker on every opcode fetch
// - full stop holds clock output low
// - refresh address on address bus
// - one automatic wait per port cycle
// - two automatic waits per acknowledge
// - three maskable response modes kept
// - pins: 11 run, 00/01 idle, 10 stop
// - idle two stops core, clock runs
// - stop wakeup counts warm-up, reset skips
// - halted: sample requests at fourth state; in the three standby modes ST_HALT samples them every clock instead
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`include "cbs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cbs_bus_control #(
  parameter int unsigned WARM_CYCLES = `CBS_WARM_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  // Address and data bus.
  output logic      [15:0] addrOut,
  output var  logic        addrOe,
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output var  logic        dataOe,
  // Bus strobes; ctlOe enables the four request strobes.
  output logic             memoryRequestN,
  output logic             portRequestN,
  output logic             readN,
  output logic             writeN,
  output var  logic        ctlOe,
  output logic             firstCycleMarkerN,
  output var  logic        haltN,
  output var  logic        busHoldGrantN,
  output var  logic        clockOut,
  // Pin inputs from outside the clock domain.
  input  wire logic        waitN,
  input  wire logic        busHoldRequestN,
  input  wire logic        intRequestN,
  input  wire logic        nmiRequestN,
  input  wire logic        modeSelectHi,
  input  wire logic        modeSelectLo
);

  // The warm-up counter is 16 bits wide.
  if (WARM_CYCLES < 1 || WARM_CYCLES > 65535) begin : gWarmCheck
    $error("WARM_CYCLES must lie between 1 and 65535.");
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [13:0] syncA;
  logic [13:0] syncB;
  logic        nmiLast;
  logic        waitS;
  logic        busReqS;
  logic        intReqS;
  logic        nmiS;
  logic [1:0]  modeS;
  logic [7:0]  dataS;

  // Two flops on every pin; T2 dwells two clocks so wait and data are fresh.
  always_ff @(posedge clock) begin
    if (reset) begin
      syncA   <= 14'h3F00;
      syncB   <= 14'h3F00;
      nmiLast <= 1'h1;
    end else begin
      syncA   <= {waitN, busHoldRequestN, intRequestN, nmiRequestN, modeSelectHi,
                  modeSelectLo, dataIn};
      syncB   <= syncA;
      nmiLast <= syncB[10];
    end
  end

  assign waitS   = syncB[13];
  assign busReqS = syncB[12];
  assign intReqS = syncB[11];
  assign nmiS    = syncB[10];
  assign modeS   = syncB[9:8];
  assign dataS   = syncB[7:0];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave with one wait state so that read data comes from a flop.

  logic       pend;
  logic [7:0] pAddr;
  logic       pWrite;
  logic       pWord;
  logic       wrStrobe;
  logic [31:0] rdValue;

  // Address phase taken with hready high; data phase is two cycles.
  always_ff @(posedge clock) begin
    if (reset) begin
      pend      <= 1'h0;
      pAddr     <= 8'h00;
      pWrite    <= 1'h0;
      pWord     <= 1'h0;
      hreadyout <= 1'h1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'h0;
    end else if (pend) begin
      pend      <= 1'h0;
      hreadyout <= 1'h1;
      hrdata    <= pWrite ? 32'h0000_0000 : rdValue;
    end else if (hready && hsel && htrans[1]) begin
      pend      <= 1'h1;
      pAddr     <= haddr[7:0];
      pWrite    <= hwrite;
      pWord     <= (hsize == 3'h2);
      hreadyout <= 1'h0;
    end
  end

  // Only whole-word writes land.
  assign wrStrobe = pend && pWrite && pWord;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Software registers.

  logic        irqEnableFlop;
  logic [1:0]  intMode;
  logic [15:0] cycAddr;
  logic [7:0]  cycData;
  logic [2:0]  cmdKind;
  logic        cmdPending;
  logic [1:0]  ackCode;
  logic [7:0]  rdData;
  logic        nmiPending;
  logic        halted;
  logic [6:0]  refresh;
  logic        launch;
  logic        ackSetNmi;
  logic        ackSetInt;
  logic        readDone;
  logic        clockHeld;
  cbs_pkg::cbs_state_e state;
  localparam logic [31:0] CtrlReset = `CBS_CTRL_RESET;

  // A software write wins over the hardware clear of the enable flop.
  always_ff @(posedge clock) begin
    if (reset) begin
      irqEnableFlop <= CtrlReset[`CBS_CTRL_IFF];
      intMode       <= CtrlReset[`CBS_CTRL_MODE_HI:`CBS_CTRL_MODE_LO];
      cycAddr       <= 16'h0000;
      cycData       <= 8'h00;
    end else begin
      if (wrStrobe && pAddr == `CBS_OFF_CTRL) begin
        irqEnableFlop <= hwdata[`CBS_CTRL_IFF];
        if (hwdata[`CBS_CTRL_MODE_HI:`CBS_CTRL_MODE_LO] != 2'h3) begin
          intMode <= hwdata[`CBS_CTRL_MODE_HI:`CBS_CTRL_MODE_LO];
        end
      end else if (ackSetNmi || ackSetInt) begin
        irqEnableFlop <= 1'h0;
      end
      if (wrStrobe && pAddr == `CBS_OFF_ADDR) begin
        cycAddr <= hwdata[15:0];
      end
      if (wrStrobe && pAddr == `CBS_OFF_WDATA) begin
        cycData <= hwdata[7:0];
      end
    end
  end

  // A command is refused while one is pending or the core is halted; busy shows it.
  always_ff @(posedge clock) begin
    if (reset) begin
      cmdKind    <= `CBS_KIND_FETCH;
      cmdPending <= 1'h0;
    end else if (wrStrobe && pAddr == `CBS_OFF_CMD && !cmdPending && !halted
                 && hwdata[2:0] < `CBS_KIND_INTA) begin
      cmdKind    <= hwdata[2:0];
      cmdPending <= 1'h1;
    end else if (launch) begin
      cmdPending <= 1'h0;
    end
  end

  // Sticky acknowledge code: a new acknowledge wins over the clearing write.
  always_ff @(posedge clock) begin
    if (reset) begin
      ackCode <= 2'h0;
    end else if (ackSetNmi) begin
      ackCode <= `CBS_ACK_NMI;
    end else if (ackSetInt) begin
      ackCode <= `CBS_ACK_INT;
    end else if (wrStrobe && pAddr == `CBS_OFF_STATUS) begin
      ackCode <= 2'h0;
    end
  end

  // Non-maskable request latched on its falling edge; a new edge wins over the clear.
  always_ff @(posedge clock) begin
    if (reset) begin
      nmiPending <= 1'h0;
    end else if (nmiLast && !nmiS) begin
      nmiPending <= 1'h1;
    end else if (ackSetNmi) begin
      nmiPending <= 1'h0;
    end
  end

  // Read multiplexer, decoded by offset.
  always_comb begin
    rdValue = 32'h0000_0000;
    if (pAddr == `CBS_OFF_CTRL) begin
      rdValue[`CBS_CTRL_IFF] = irqEnableFlop;
      rdValue[`CBS_CTRL_MODE_HI:`CBS_CTRL_MODE_LO] = intMode;
    end else if (pAddr == `CBS_OFF_ADDR) begin
      rdValue[15:0] = cycAddr;
    end else if (pAddr == `CBS_OFF_WDATA) begin
      rdValue[7:0] = cycData;
    end else if (pAddr == `CBS_OFF_CMD) begin
      rdValue[2:0] = cmdKind;
    end else if (pAddr == `CBS_OFF_STATUS) begin
      rdValue[`CBS_ST_BUSY]    = cmdPending || (state != cbs_pkg::ST_IDLE);
      rdValue[`CBS_ST_HALTED]  = halted;
      rdValue[`CBS_ST_GRANTED] = !busHoldGrantN;
      rdValue[`CBS_ST_NMI]     = nmiPending;
      rdValue[`CBS_ST_CLKHELD] = clockHeld;
      rdValue[`CBS_ST_MODE_LO+1:`CBS_ST_MODE_LO] = modeS;
      rdValue[`CBS_ST_ACK_LO+1:`CBS_ST_ACK_LO]   = ackCode;
      rdValue[`CBS_ST_REFR_LO+6:`CBS_ST_REFR_LO] = refresh;
    end else if (pAddr == `CBS_OFF_RDATA) begin
      rdValue[7:0] = rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Machine cycle sequencer, one clock per T state except T2, which dwells for waits.

  cbs_pkg::cbs_pins_s pins;
  logic [2:0]  kind;
  logic [2:0]  autoCnt;
  logic [15:0] warmCnt;
  logic [1:0]  haltMode;
  logic        accept;
  logic        isFetch;
  logic        isRead;

  assign accept  = nmiPending || (!intReqS && irqEnableFlop);
  assign isFetch = (kind == `CBS_KIND_FETCH) || (kind == `CBS_KIND_HALT);
  assign isRead  = (kind == `CBS_KIND_MEMRD) || (kind == `CBS_KIND_IORD)
                   || (kind == `CBS_KIND_INTA);
  assign launch  = (state == cbs_pkg::ST_IDLE) && busReqS && cmdPending && !halted;
  assign ackSetNmi = (state == cbs_pkg::ST_ACK) && nmiPending;
  assign ackSetInt = (state == cbs_pkg::ST_T3) && (kind == `CBS_KIND_INTA);
  assign readDone  = (state == cbs_pkg::ST_T2) && autoCnt == 3'h0 && waitS && (isRead || isFetch);

  // Captured read data or response vector.
  always_ff @(posedge clock) begin
    if (reset) begin
      rdData <= 8'h00;
    end else if (readDone && !isFetch) begin
      rdData <= dataS;
    end
  end

  // Sequencer; bus hold is honoured only between machine cycles.
  always_ff @(posedge clock) begin
    if (reset) begin
      state         <= cbs_pkg::ST_IDLE;
      pins          <= '{16'h0000, 8'h00, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
      kind          <= `CBS_KIND_FETCH;
      autoCnt       <= 3'h0;
      warmCnt       <= 16'h0000;
      haltMode      <= `CBS_MODE_RUN;
      halted        <= 1'h0;
      haltN         <= 1'h1;
      addrOe        <= 1'h1;
      ctlOe         <= 1'h1;
      dataOe        <= 1'h0;
      busHoldGrantN <= 1'h1;
      refresh       <= 7'h00;
    end else begin
      case (state)
        cbs_pkg::ST_IDLE: begin
          if (!busReqS) begin
            addrOe <= 1'h0;
            ctlOe  <= 1'h0;
            dataOe <= 1'h0;
            state  <= cbs_pkg::ST_HOLD;
          end else if (halted || cmdPending) begin
            // Halted in run mode keeps fetching at the held address.
            kind         <= halted ? `CBS_KIND_FETCH : cmdKind;
            pins.addr    <= cycAddr;
            pins.data    <= cycData;
            pins.firstN  <= !(halted || cmdKind == `CBS_KIND_FETCH
                              || cmdKind == `CBS_KIND_HALT);
            pins.memReqN <= !(halted || cmdKind <= `CBS_KIND_MEMWR
                              || cmdKind == `CBS_KIND_HALT);
            pins.readN   <= !(halted || cmdKind <= `CBS_KIND_MEMRD
                              || cmdKind == `CBS_KIND_HALT);
            state        <= cbs_pkg::ST_T1;
          end
        end
        cbs_pkg::ST_T1: begin
          if (kind == `CBS_KIND_MEMWR || kind == `CBS_KIND_IOWR) begin
            dataOe <= 1'h1;
          end
          if (kind == `CBS_KIND_IORD || kind == `CBS_KIND_IOWR) begin
            pins.portReqN <= 1'h0;
            pins.readN    <= (kind != `CBS_KIND_IORD);
          end
          if (kind == `CBS_KIND_INTA) begin
            pins.portReqN <= 1'h0;
          end
          pins.writeN <= !(kind == `CBS_KIND_MEMWR || kind == `CBS_KIND_IOWR);
          autoCnt <= `CBS_SYNC_WAIT + ((kind == `CBS_KIND_INTA) ? `CBS_AUTO_WAIT_INTA :
                     (kind == `CBS_KIND_IORD || kind == `CBS_KIND_IOWR) ?
                     `CBS_AUTO_WAIT_IO : 3'h0);
          state <= cbs_pkg::ST_T2;
        end
        cbs_pkg::ST_T2: begin
          if (autoCnt != 3'h0) begin
            autoCnt <= autoCnt - 3'h1;
          end else if (waitS) begin
            pins.readN    <= 1'h1;
            pins.writeN   <= 1'h1;
            pins.portReqN <= 1'h1;
            pins.firstN   <= 1'h1;
            if (isFetch) begin
              pins.addr <= {9'h000, refresh};
            end else begin
              pins.memReqN <= 1'h1;
            end
            state <= cbs_pkg::ST_T3;
          end
        end
        cbs_pkg::ST_T3: begin
          dataOe       <= 1'h0;
          pins.memReqN <= 1'h1;
          state        <= isFetch ? cbs_pkg::ST_T4 : cbs_pkg::ST_IDLE;
        end
        cbs_pkg::ST_T4: begin
          refresh <= refresh + 7'h01;
          if (kind == `CBS_KIND_HALT) begin
            halted   <= 1'h1;
            haltN    <= 1'h0;
            haltMode <= modeS;
            state    <= (modeS == `CBS_MODE_RUN) ? cbs_pkg::ST_IDLE : cbs_pkg::ST_HALT;
          end else if (accept) begin
            state <= cbs_pkg::ST_ACK;
          end else begin
            state <= cbs_pkg::ST_IDLE;
          end
        end
        cbs_pkg::ST_HALT: begin
          if (accept && haltMode == `CBS_MODE_STOP) begin
            warmCnt <= 16'(WARM_CYCLES - 1);
            state   <= cbs_pkg::ST_WARM;
          end else if (accept) begin
            state <= cbs_pkg::ST_ACK;
          end
        end
        cbs_pkg::ST_WARM: begin
          if (warmCnt == 16'h0000) begin
            state <= cbs_pkg::ST_ACK;
          end else begin
            warmCnt <= warmCnt - 16'h0001;
          end
        end
        cbs_pkg::ST_ACK: begin
          halted <= 1'h0;
          haltN  <= 1'h1;
          if (nmiPending) begin
            state <= cbs_pkg::ST_IDLE;
          end else begin
            kind         <= `CBS_KIND_INTA;
            pins.addr    <= cycAddr;
            pins.firstN  <= 1'h0;
            pins.memReqN <= 1'h1;
            pins.readN   <= 1'h1;
            state        <= cbs_pkg::ST_T1;
          end
        end
        cbs_pkg::ST_HOLD: begin
          if (busReqS) begin
            busHoldGrantN <= 1'h1;
            addrOe        <= 1'h1;
            ctlOe         <= 1'h1;
            state         <= cbs_pkg::ST_IDLE;
          end else begin
            busHoldGrantN <= 1'h0;
          end
        end
        default: begin
          state <= cbs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock output: stops low in oscillator-only idle, full stop and warm-up.

  assign clockHeld = (state == cbs_pkg::ST_WARM)
                     || (state == cbs_pkg::ST_HALT && haltMode != `CBS_MODE_CLOCK_OUT_STANDBY);

  // Half-rate clock; holding it low costs one half period of latency on wakeup.
  always_ff @(posedge clock) begin
    if (reset) begin
      clockOut <= 1'h0;
    end else if (clockHeld) begin
      clockOut <= 1'h0;
    end else begin
      clockOut <= !clockOut;
    end
  end

  // Pin fields straight from the sequencer flops.
  assign addrOut           = pins.addr;
  assign dataOut           = pins.data;
  assign memoryRequestN    = pins.memReqN;
  assign portRequestN      = pins.portReqN;
  assign readN             = pins.readN;
  assign writeN            = pins.writeN;
  assign firstCycleMarkerN = pins.firstN;

endmodule : cbs_bus_control
`default_nettype wire

// *** verif/cbs_bus_control_properties.sv ***
// Checker: strobe, float and wait relations at the block's pins.
// Assumes a bind onto cbs_bus_control; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cbs_bus_control_properties (
  // Clock, reset and register bus handshake.
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  // Bus pins.
  input wire logic       addrOe,
  input wire logic       dataOe,
  input wire logic       ctlOe,
  input wire logic       memoryRequestN,
  input wire logic       portRequestN,
  input wire logic       readN,
  input wire logic       writeN,
  input wire logic       firstCycleMarkerN,
  input wire logic       busHoldGrantN,
  input wire logic       haltN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  mem_addr_valid_a: assert property (!memoryRequestN |-> addrOe && ctlOe)
    else $error("memory strobe unqualified");
  port_no_mem_a: assert property (!portRequestN |-> memoryRequestN && addrOe)
    else $error("port strobe overlap");
  grant_floats_a: assert property (!busHoldGrantN |-> !addrOe && !ctlOe && !dataOe)
    else $error("grant while driven");
  grant_after_float_a: assert property ($fell(busHoldGrantN) |-> !$past(ctlOe))
    else $error("grant too early");
  fetch_marker_a: assert property (!firstCycleMarkerN && !readN |-> !memoryRequestN)
    else $error("marker alone");
  write_data_a: assert property (!writeN |-> dataOe && readN)
    else $error("write undriven");
  read_no_drive_a: assert property (!readN |-> !dataOe)
    else $error("read while driven");
  io_auto_wait_a: assert property ($fell(portRequestN) |-> (!portRequestN) [*2])
    else $error("port wait short");
  ack_auto_wait_a: assert property ($fell(portRequestN) && !firstCycleMarkerN |->
    (!portRequestN) [*3])
    else $error("acknowledge wait short");
  ahb_answer_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("register answer late");
  // Main scenarios.
  cover property ($fell(busHoldGrantN));
  cover property ($fell(portRequestN) && !firstCycleMarkerN);
  cover property ($fell(haltN));
endmodule : cbs_bus_control_properties
bind cbs_bus_control cbs_bus_control_properties i_props (.*);
`default_nettype wire

// *** verif/cbs_bus_partner.sv ***
// Memory, port and interrupting peripheral on the far side of the bus.
// Assumes the bench picks slow answers with the slow input.
`timescale 1ns/10ps
`default_nettype none
module cbs_bus_partner #(
  parameter logic [7:0] VECTOR = 8'hA5
) (
  // Clock and pacing.
  input  wire logic        clock,
  input  wire logic        slow,
  // Pins of the block.
  input  wire logic [15:0] addrOut,
  input  wire logic [7:0]  dataOut,
  input  wire logic        memoryRequestN,
  input  wire logic        portRequestN,
  input  wire logic        readN,
  input  wire logic        writeN,
  input  wire logic        firstCycleMarkerN,
  // Answer lines.
  output var  logic [7:0]  dataIn,
  output var  logic        waitN
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  int         cnt = 0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Store while the write strobe is low.
  always @(posedge clock) if (!writeN) mem[addrOut[7:0]] <= dataOut;
  // Drive under read strobe or acknowledge; a released bus shows the inverse.
  always_comb begin
    if (!readN) dataIn = mem[addrOut[7:0]];
    else if (!portRequestN && !firstCycleMarkerN) dataIn = VECTOR;
    else dataIn = ~last;
  end
  // A slow part keeps wait low for four cycles of every strobe.
  always @(posedge clock) begin
    cnt <= (memoryRequestN && portRequestN) ? 0 : cnt + 1;
    if (!readN || !portRequestN) last <= dataIn;
  end
  assign waitN = !(slow && cnt < 4 && !(memoryRequestN && portRequestN));
endmodule : cbs_bus_partner
`default_nettype wire

// *** verif/cbs_bus_control_bench.sv ***
// Self-checking bench of the bus control block.
// Assumes the constants header; warm-up shortened to 8.
`include "cbs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cbs_bus_control_bench;
  localparam int         WARM = 8;
  localparam logic [7:0] VEC  = 8'hA5;
  logic clock = 1'b0, reset = 1'b1, hsel, hwrite, hreadyout, hresp, addrOe, dataOe, ctlOe;
  logic memoryRequestN, portRequestN, readN, writeN, firstCycleMarkerN, haltN, clockOut;
  logic busHoldGrantN, waitN, busHoldRequestN, intRequestN, nmiRequestN, slow;
  logic modeSelectHi, modeSelectLo, inFetch, prevMk, prevClk;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] addrOut, lfsr = 16'h46CD;
  logic [7:0]  dataIn, dataOut, curAddr;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  logic [7:0]  expq [$];
  wire logic   hready = hreadyout;
  int failCount = 0, testsRun = 0, rdLen, markFalls, toggles, n, a;
  always #10 clock = ~clock;
  cbs_bus_control #(.WARM_CYCLES(WARM)) i_dut (.*);
  cbs_bus_partner #(.VECTOR(VEC)) i_far (.*);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One single word transfer; the address phase is held until ready is seen.
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic idle;
    do ahb(1'b0, `CBS_OFF_STATUS, 32'h0); while (r[`CBS_ST_BUSY] !== 1'b0);
  endtask : idle
  task automatic cycle(input logic [2:0] k);
    ahb(1'b1, `CBS_OFF_CMD, {29'h0, k});
    idle();
  endtask : cycle
  // Bounded wait for the halt pin; n returns the cycles waited.
  task automatic waitHalt(input logic lvl);
    for (n = 0; n < 300 && haltN !== lvl; n++) @(posedge clock);
  endtask : waitHalt
  task automatic tallyAndFinish;
    $display("compares %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tallyAndFinish
  // Pin monitor, sampled mid-cycle where every output has settled.
  always @(negedge clock) begin
    if (!reset && !portRequestN && firstCycleMarkerN)
      chk("port address", {24'h0, curAddr}, {24'h0, addrOut[7:0]});
    if (inFetch && !memoryRequestN && readN)
      chk("refresh upper bits", 32'h0, {23'h0, addrOut[15:7]});
    if (!readN) rdLen++;
    if (!firstCycleMarkerN && prevMk) markFalls++;
    if (clockOut !== prevClk) toggles++;
    prevMk = firstCycleMarkerN;
    prevClk = clockOut;
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (30000) @(posedge clock);
    failCount++;
    $display("ERROR watchdog expected finish seen hang");
    tallyAndFinish();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, slow, inFetch, prevMk, prevClk} = 6'h0;
    {busHoldRequestN, intRequestN, nmiRequestN, modeSelectHi, modeSelectLo} = 5'h1F;
    {haddr, hwdata, hsize, htrans, curAddr} = {32'h0, 32'h0, 3'h2, 2'h0, 8'h0};
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    ahb(1'b0, `CBS_OFF_CTRL, 32'h0);
    chk("control reset", `CBS_CTRL_RESET, r);
    chk("response", 32'h0, {31'h0, hresp});
    chk("halt pin idle", 32'h1, {31'h0, haltN});
    $display("test reset done");
    // Random bytes through memory and port cycles; reads come from a slow part.
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      curAddr = lfsr[7:0];
      slow <= i[0];
      expq.push_back(lfsr[15:8]);
      ahb(1'b1, `CBS_OFF_ADDR, {16'h0, lfsr});
      ahb(1'b1, `CBS_OFF_WDATA, {24'h0, lfsr[15:8]});
      cycle(i[1] ? `CBS_KIND_IOWR : `CBS_KIND_MEMWR);
      slow <= 1'b1;
      cycle(i[1] ? `CBS_KIND_IORD : `CBS_KIND_MEMRD);
      ahb(1'b0, `CBS_OFF_RDATA, 32'h0);
      chk("read back", {24'h0, expq.pop_front()}, r);
    end
    slow <= 1'b0;
    rdLen = 0;
    cycle(`CBS_KIND_MEMRD);
    a = rdLen;
    slow <= 1'b1;
    rdLen = 0;
    cycle(`CBS_KIND_MEMRD);
    chk("wait stretches read", 32'h1, 32'(rdLen > a));
    inFetch = 1'b1;
    markFalls = 0;
    cycle(`CBS_KIND_FETCH);
    cycle(`CBS_KIND_FETCH);
    inFetch = 1'b0;
    chk("fetch markers", 32'h2, 32'(markFalls));
    $display("test bus cycles done");
    busHoldRequestN <= 1'b0;
    for (n = 0; n < 30 && busHoldGrantN !== 1'b0; n++) @(posedge clock);
    @(negedge clock);
    chk("grant and float", 32'h0, {28'h0, busHoldGrantN, addrOe, ctlOe, dataOe});
    busHoldRequestN <= 1'b1;
    for (n = 0; n < 30 && busHoldGrantN !== 1'b1; n++) @(posedge clock);
    chk("grant released", 32'h1, {31'h0, busHoldGrantN});
    $display("test hold done");
    // Every halt mode, woken by the non-maskable request.
    for (int m = 0; m < 4; m++) begin
      {modeSelectHi, modeSelectLo} <= 2'(m);
      repeat (4) @(posedge clock);
      ahb(1'b0, `CBS_OFF_STATUS, 32'h0);
      chk("mode pins", 32'(m), {30'h0, r[6:5]});
      ahb(1'b1, `CBS_OFF_CMD, {29'h0, `CBS_KIND_HALT});
      waitHalt(1'b0);
      chk("halt pin low", 32'h0, {31'h0, haltN});
      repeat (4) @(posedge clock);
      toggles = 0;
      repeat (8) @(posedge clock);
      chk("clock output runs", 32'(m % 2), 32'(toggles != 0));
      nmiRequestN <= 1'b0;
      repeat (3) @(posedge clock);
      nmiRequestN <= 1'b1;
      waitHalt(1'b1);
      if (m == 2)
        chk("warm-up span", 32'h1, 32'(n >= WARM));
      idle();
      chk("nmi ack", {30'h0, `CBS_ACK_NMI}, {30'h0, r[9:8]});
      ahb(1'b1, `CBS_OFF_STATUS, 32'h0);
    end
    $display("test halt modes done");
    for (int md = 0; md < 3; md++) begin
      ahb(1'b1, `CBS_OFF_CTRL, {29'h0, 2'(md), 1'b0});
      ahb(1'b0, `CBS_OFF_CTRL, 32'h0);
      chk("interrupt mode", 32'(md), {30'h0, r[2:1]});
    end
    ahb(1'b1, `CBS_OFF_CTRL, 32'h0);
    ahb(1'b1, `CBS_OFF_CMD, {29'h0, `CBS_KIND_HALT});
    waitHalt(1'b0);
    intRequestN <= 1'b0;
    repeat (30) @(posedge clock);
    chk("masked request ignored", 32'h0, {31'h0, haltN});
    ahb(1'b1, `CBS_OFF_CTRL, 32'h1);
    waitHalt(1'b1);
    idle();
    intRequestN <= 1'b1;
    chk("int ack", {30'h0, `CBS_ACK_INT}, {30'h0, r[9:8]});
    ahb(1'b0, `CBS_OFF_RDATA, 32'h0);
    chk("vector", {24'h0, VEC}, r);
    ahb(1'b0, `CBS_OFF_CTRL, 32'h0);
    chk("enable cleared", 32'h0, {31'h0, r[0]});
    $display("test maskable done");
    tallyAndFinish();
  end
endmodule : cbs_bus_control_bench
`default_nettype wire
